// *** core/osadc_regs.svh ***
`ifndef OSADC_REGS_SVH
`define OSADC_REGS_SVH

// register byte offsets
`define OSADC_OFS_STATUS 12'h000
`define OSADC_OFS_MASK 12'h004
`define OSADC_OFS_STATE 12'h008
`define OSADC_OFS_FILT 12'h00C
`define OSADC_OFS_COMP 12'h010

// status / mask bit positions
`define OSADC_EV_FILT 0
`define OSADC_EV_COMP 1
`define OSADC_EV_SYNC 2
`define OSADC_EV_W 3

// state register fields
`define OSADC_ST_BUSY 0
`define OSADC_ST_DRDY_N 1
`define OSADC_ST_SEL_LO 2
`define OSADC_ST_SEL_HI 3

// reset values
`define OSADC_MASK_RST 3'h0
`define OSADC_DRDY_N_RST 1'h1

// decimation: last count and result shift per select code
`define OSADC_LAST_256 14'h00FF
`define OSADC_LAST_1024 14'h03FF
`define OSADC_LAST_4096 14'h0FFF
`define OSADC_LAST_16384 14'h3FFF
`define OSADC_SHIFT_256 4'h8
`define OSADC_SHIFT_1024 4'hA
`define OSADC_SHIFT_4096 4'hC
`define OSADC_SHIFT_16384 4'hE

// timing
`define OSADC_CLK_PERIOD_NS 40
`define OSADC_T_CONV_NS 652
`define OSADC_CONV_CYC (`OSADC_T_CONV_NS / `OSADC_CLK_PERIOD_NS)

`endif

// *** core/osadc_pkg.sv ***
package osadc_pkg;

  typedef enum logic [1:0] {
    OSADC_IDLE = 2'b00,
    OSADC_CONV = 2'b01
  } osadc_state_t;

  typedef enum logic [1:0] {
    OSADC_DF_256 = 2'b00,
    OSADC_DF_1024 = 2'b01,
    OSADC_DF_4096 = 2'b10,
    OSADC_DF_16384 = 2'b11
  } osadc_df_t;

  // one conversion's worth of codes from the converter core
  typedef struct packed {
    logic [31:0] core;
    logic [13:0] diff;
    logic [7:0] cm;
  } osadc_sample_t;

  typedef struct packed {
    logic [13:0] diff;
    logic [7:0] cm;
  } osadc_comp_t;

endpackage

// *** core/osadc_top.sv ***
// Contract
// - filtered serial out driven only while its read enable is low
// - no-latency serial out driven only while its read enable is low
// - select pins 00/01/10/11 give decimation 256/1024/4096/16384
// - conversion clock rising edge starts a new conversion
// - alignment pulse sets the decimating filter phase
// - data-ready falls when a new filtered word is loaded
// - filtered word shifts out msb first on shift clock rising edges
// - composite word shifts out msb first on its own shift clock
// - busy rises at conversion start and falls when it ends
// - composite is 14 differential bits plus 8 common-mode bits
// - composite refreshed every conversion with no latency
// - filtered result is lowpass filtered and decimated core stream
// - at conversion end the core result feeds the filter
// - full-scale span maps onto 2^32 two's complement levels
//
// The implementer's own choices: the APB slave port and the address map.
`timescale 1ns/10ps
`default_nettype none
`include "osadc_regs.svh"

module osadc_top
  import osadc_pkg::*;
(
  // clock and reset
  input wire logic CLOCK_I,
  input wire logic SRST_I,
  // apb slave
  input wire logic PSEL_I,
  input wire logic PENABLE_I,
  input wire logic PWRITE_I,
  input wire logic [11:0] PADDR_I,
  input wire logic [31:0] PWDATA_I,
  output logic [31:0] PRDATA_O,
  output logic PREADY_O,
  output logic PSLVERR_O,
  output logic IRQ_O,
  // conversion control pins
  input wire logic CONVERSION_CLOCK_I,
  input wire logic FILTER_SYNC_I,
  input wire logic DECIMATION_SELECT_0_I,
  input wire logic DECIMATION_SELECT_1_I,
  output logic BUSY_O,
  output logic FILTERED_DATA_READY_N_O,
  // filtered serial port
  input wire logic FILTERED_READ_ENABLE_N_I,
  input wire logic FILTERED_SHIFT_CLOCK_I,
  output logic FILTERED_SERIAL_OUT_O,
  output logic FILTERED_SERIAL_OE_O,
  // no-latency serial port
  input wire logic NOLATENCY_READ_ENABLE_N_I,
  input wire logic NOLATENCY_SHIFT_CLOCK_I,
  output logic NOLATENCY_SERIAL_OUT_O,
  output logic NOLATENCY_SERIAL_OE_O,
  // converter core
  input wire osadc_sample_t CORE_SAMPLE_I,
  output logic CORE_START_O
);

  localparam int CONV_CYC = `OSADC_CONV_CYC;
  localparam int PIN_N = 8;

  // pin synchronisers: stage one feeds stage two only
  logic [PIN_N-1:0] pin_raw;
  logic [PIN_N-1:0] pin_s1;
  logic [PIN_N-1:0] pin_s2;
  logic [PIN_N-1:0] pin_s3;
  assign pin_raw = {CONVERSION_CLOCK_I, FILTER_SYNC_I,
                    DECIMATION_SELECT_0_I, DECIMATION_SELECT_1_I,
                    FILTERED_READ_ENABLE_N_I, FILTERED_SHIFT_CLOCK_I,
                    NOLATENCY_READ_ENABLE_N_I, NOLATENCY_SHIFT_CLOCK_I};

  always_ff @(posedge CLOCK_I) begin
    pin_s1 <= pin_raw;
    pin_s2 <= pin_s1;
    pin_s3 <= pin_s2;
  end

  wire mclk_rise = pin_s2[7] & ~pin_s3[7];
  wire sync_rise = pin_s2[6] & ~pin_s3[6];
  wire [1:0] sel = pin_s2[5:4];
  wire rd_a_n = pin_s2[3];
  wire sck_a_rise = pin_s2[2] & ~pin_s3[2];
  wire rd_b_n = pin_s2[1];
  wire sck_b_rise = pin_s2[0] & ~pin_s3[0];

  // conversion sequencer
  osadc_state_t state;
  osadc_state_t next_state;
  logic [4:0] conv_cnt;
  logic conv_done;

  wire conv_start = (state == OSADC_IDLE) && mclk_rise;
  wire conv_last = (conv_cnt == 5'(CONV_CYC - 1));

  always_comb begin
    next_state = state;
    conv_done = 1'b0;
    case (state)
      OSADC_IDLE: begin
        if (conv_start) begin
          next_state = OSADC_CONV;
        end
      end
      OSADC_CONV: begin
        if (conv_last) begin
          next_state = OSADC_IDLE;
          conv_done = 1'b1;
        end
      end
      default: next_state = OSADC_IDLE;
    endcase
  end

  always_ff @(posedge CLOCK_I) begin
    if (SRST_I) begin
      state <= OSADC_IDLE;
      conv_cnt <= 5'h00;
    end else begin
      state <= next_state;
      conv_cnt <= (state == OSADC_CONV) ? conv_cnt + 5'h01 : 5'h00;
    end
  end

  assign BUSY_O = (state == OSADC_CONV);
  assign CORE_START_O = conv_start;

  // decimation factor from the straps
  logic [13:0] dec_last;
  logic [3:0] dec_shift;
  always_comb begin
    case (osadc_df_t'(sel))
      OSADC_DF_256: begin
        dec_last = `OSADC_LAST_256;
        dec_shift = `OSADC_SHIFT_256;
      end
      OSADC_DF_1024: begin
        dec_last = `OSADC_LAST_1024;
        dec_shift = `OSADC_SHIFT_1024;
      end
      OSADC_DF_4096: begin
        dec_last = `OSADC_LAST_4096;
        dec_shift = `OSADC_SHIFT_4096;
      end
      default: begin
        dec_last = `OSADC_LAST_16384;
        dec_shift = `OSADC_SHIFT_16384;
      end
    endcase
  end

  // boxcar average: lowpass plus decimate; 46 bits cannot overflow
  // with 16384 full-scale 32-bit samples
  logic [45:0] acc;
  logic [13:0] dec_cnt;
  logic [31:0] filt_word;
  logic filt_load;
  wire [45:0] sample_ext = {{14{CORE_SAMPLE_I.core[31]}},
                            CORE_SAMPLE_I.core};
  wire [45:0] acc_sum = acc + sample_ext;
  wire [45:0] acc_avg = $signed(acc_sum) >>> dec_shift;
  wire dec_wrap = conv_done && (dec_cnt == dec_last);

  always_ff @(posedge CLOCK_I) begin
    if (SRST_I) begin
      acc <= 46'h0;
      dec_cnt <= 14'h0;
      filt_load <= 1'b0;
      filt_word <= 32'h0;
    end else begin
      filt_load <= 1'b0;
      // a sample landing with the pulse is dropped to keep alignment
      if (sync_rise) begin
        acc <= 46'h0;
        dec_cnt <= 14'h0;
      end else if (dec_wrap) begin
        acc <= 46'h0;
        dec_cnt <= 14'h0;
        filt_word <= acc_avg[31:0];
        filt_load <= 1'b1;
      end else if (conv_done) begin
        acc <= acc_sum;
        dec_cnt <= dec_cnt + 14'h1;
      end
    end
  end

  // data ready: low on a new word, else high at each conversion start
  logic drdy_n;
  always_ff @(posedge CLOCK_I) begin
    if (SRST_I) begin
      drdy_n <= `OSADC_DRDY_N_RST;
    end else if (filt_load) begin
      drdy_n <= 1'b0;
    end else if (conv_start) begin
      drdy_n <= 1'b1;
    end
  end
  assign FILTERED_DATA_READY_N_O = drdy_n;

  // output shift registers; load wins over a shift in the same cycle
  logic [31:0] sreg_a;
  logic [21:0] sreg_b;
  osadc_comp_t comp_now;
  osadc_comp_t comp_last;
  assign comp_now = '{diff: CORE_SAMPLE_I.diff, cm: CORE_SAMPLE_I.cm};

  always_ff @(posedge CLOCK_I) begin
    if (SRST_I) begin
      sreg_a <= 32'h0;
      sreg_b <= 22'h0;
      comp_last <= '0;
    end else begin
      if (filt_load) begin
        sreg_a <= filt_word;
      end else if (sck_a_rise && !rd_a_n) begin
        sreg_a <= {sreg_a[30:0], 1'b0};
      end
      if (conv_done) begin
        sreg_b <= comp_now;
        comp_last <= comp_now;
      end else if (sck_b_rise && !rd_b_n) begin
        sreg_b <= {sreg_b[20:0], 1'b0};
      end
    end
  end

  assign FILTERED_SERIAL_OUT_O = sreg_a[31];
  assign FILTERED_SERIAL_OE_O = ~rd_a_n;
  assign NOLATENCY_SERIAL_OUT_O = sreg_b[21];
  assign NOLATENCY_SERIAL_OE_O = ~rd_b_n;

  // apb slave: zero wait states
  logic [`OSADC_EV_W-1:0] status;
  logic [`OSADC_EV_W-1:0] mask;
  logic [31:0] rdata;
  logic [31:0] next_rdata;
  wire apb_acc = PSEL_I && PENABLE_I;
  wire sel_status = (PADDR_I == `OSADC_OFS_STATUS);
  wire sel_mask = (PADDR_I == `OSADC_OFS_MASK);
  wire sel_state = (PADDR_I == `OSADC_OFS_STATE);
  wire sel_filt = (PADDR_I == `OSADC_OFS_FILT);
  wire sel_comp = (PADDR_I == `OSADC_OFS_COMP);
  wire addr_ok = sel_status | sel_mask | sel_state | sel_filt | sel_comp;
  wire rd_status = apb_acc && !PWRITE_I && sel_status;
  wire [`OSADC_EV_W-1:0] ev;
  assign ev[`OSADC_EV_FILT] = filt_load;
  assign ev[`OSADC_EV_COMP] = conv_done;
  assign ev[`OSADC_EV_SYNC] = sync_rise;

  always_comb begin
    next_rdata = 32'h0;
    if (sel_status) begin
      next_rdata[`OSADC_EV_W-1:0] = status;
    end else if (sel_mask) begin
      next_rdata[`OSADC_EV_W-1:0] = mask;
    end else if (sel_state) begin
      next_rdata[`OSADC_ST_BUSY] = BUSY_O;
      next_rdata[`OSADC_ST_DRDY_N] = drdy_n;
      next_rdata[`OSADC_ST_SEL_HI:`OSADC_ST_SEL_LO] = sel;
    end else if (sel_filt) begin
      next_rdata = filt_word;
    end else if (sel_comp) begin
      next_rdata[21:0] = comp_last;
    end
  end

  always_ff @(posedge CLOCK_I) begin
    if (SRST_I) begin
      status <= '0;
      mask <= `OSADC_MASK_RST;
      rdata <= 32'h0;
    end else begin
      // the read clears only the bits it captured in setup, so an event
      // landing between setup and access is kept; a new event wins
      status <= (rd_status ? (status & ~rdata[`OSADC_EV_W-1:0]) : status)
                | ev;
      if (apb_acc && PWRITE_I && sel_mask) begin
        mask <= PWDATA_I[`OSADC_EV_W-1:0];
      end
      if (PSEL_I && !PENABLE_I && !PWRITE_I) begin
        rdata <= next_rdata;
      end
    end
  end

  // read data is captured in setup, so it stands through the access
  assign PRDATA_O = rdata;
  assign PREADY_O = 1'b1;
  assign PSLVERR_O = apb_acc && !addr_ok;
  assign IRQ_O = |(status & mask);

  // checks
  default clocking cb @(posedge CLOCK_I); endclocking
  default disable iff (SRST_I);

  chk_oe_filtered: assert property (
    $past(FILTERED_READ_ENABLE_N_I, 2) == !FILTERED_SERIAL_OE_O ||
    $past(SRST_I, 2))
    else $error("filtered output enable does not follow read enable");

  chk_oe_nolatency: assert property (
    $past(NOLATENCY_READ_ENABLE_N_I, 2) == !NOLATENCY_SERIAL_OE_O ||
    $past(SRST_I, 2))
    else $error("no-latency output enable does not follow read enable");

  chk_df_map: assert property (
    dec_last == ((sel == 2'b00) ? 14'h00FF : (sel == 2'b01) ? 14'h03FF :
                 (sel == 2'b10) ? 14'h0FFF : 14'h3FFF))
    else $error("decimation select not mapped to its factor");

  chk_conv_start: assert property (
    (state == OSADC_IDLE && mclk_rise) |=> BUSY_O && CORE_START_O == 1'b0)
    else $error("conversion edge did not start a conversion");

  chk_busy_len: assert property (
    $rose(BUSY_O) |-> BUSY_O [*8] ##1 BUSY_O [*8] ##1 !BUSY_O)
    else $error("busy does not last the conversion time");

  chk_drdy_fall: assert property (
    $fell(FILTERED_DATA_READY_N_O) |-> $past(filt_load) &&
    sreg_a == filt_word)
    else $error("data ready fell without a new filtered word");

  chk_drdy_low: assert property (
    filt_load |=> !FILTERED_DATA_READY_N_O)
    else $error("data ready did not fall after a new filtered word");

  chk_shift_a: assert property (
    (sck_a_rise && !rd_a_n && !filt_load) |=>
    sreg_a == {$past(sreg_a[30:0]), 1'b0})
    else $error("filtered word did not advance on shift clock");

  chk_shift_b: assert property (
    (sck_b_rise && !rd_b_n && !conv_done) |=>
    sreg_b == {$past(sreg_b[20:0]), 1'b0})
    else $error("no-latency word did not advance on shift clock");

  chk_comp_fresh: assert property (
    conv_done |=> sreg_b == {$past(CORE_SAMPLE_I.diff),
                             $past(CORE_SAMPLE_I.cm)})
    else $error("composite word not loaded at conversion end");

  chk_sync_restart: assert property (
    sync_rise |=> dec_cnt == 14'h0 && acc == 46'h0 && !filt_load)
    else $error("alignment pulse did not restart decimation");

endmodule
`default_nettype wire

// *** verif/osadc_serial_host.sv ***
`timescale 1ns/10ps
`default_nettype none
module osadc_serial_host #(
  parameter int W = 32
) (
  // bench clock
  input wire logic clk_i,
  // serial pins
  input wire logic line_i,
  output logic en_n_o,
  output logic sck_o
);
  // the shift clock stands low between frames
  initial begin
    en_n_o = 1'b1;
    sck_o = 1'b0;
  end
  // the bit is taken half a period after the falling edge, so the
  // synchronised shift inside the device has settled
  task automatic read(output logic [W-1:0] w);
    @(posedge clk_i);
    en_n_o <= 1'b0;
    repeat (5) @(posedge clk_i);
    for (int i = W - 1; i >= 0; i--) begin
      w[i] = line_i;
      sck_o <= 1'b1;
      repeat (4) @(posedge clk_i);
      sck_o <= 1'b0;
      repeat (4) @(posedge clk_i);
    end
    en_n_o <= 1'b1;
    repeat (5) @(posedge clk_i);
  endtask
endmodule
`default_nettype wire

// *** verif/tb.sv ***
`timescale 1ns/10ps
`default_nettype none
module tb;
  import osadc_pkg::*;
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, q, w;
  logic pready, pslverr, irq, err, busy, drdy_n, start;
  logic conv = 1'b0, sync = 1'b0, sel0 = 1'b0, decimation_select_1 = 1'b0;
  logic fa_en_n, fa_sck, fa_out, fa_oe, nl_en_n, nl_sck, nl_out, nl_oe;
  logic [21:0] cw;
  osadc_sample_t smp = '0;
  wire fa_line = fa_oe ? fa_out : 1'bz;
  wire nl_line = nl_oe ? nl_out : 1'bz;
  int mismatches = 0, total_checks = 0, n, starts = 0;
  logic [1:0] sel_row [4] = '{2'h0, 2'h1, 2'h2, 2'h3};

  always #20 clk = ~clk;

  always @(posedge clk) begin
    if (start === 1'b1) starts++;
  end

  osadc_top uut (
    .CLOCK_I(clk), .SRST_I(srst), .PSEL_I(psel), .PENABLE_I(penable),
    .PWRITE_I(pwrite), .PADDR_I(paddr), .PWDATA_I(pwdata),
    .PRDATA_O(prdata), .PREADY_O(pready), .PSLVERR_O(pslverr),
    .IRQ_O(irq), .CONVERSION_CLOCK_I(conv), .FILTER_SYNC_I(sync),
    .DECIMATION_SELECT_0_I(sel0), .DECIMATION_SELECT_1_I(decimation_select_1),
    .BUSY_O(busy), .FILTERED_DATA_READY_N_O(drdy_n),
    .FILTERED_READ_ENABLE_N_I(fa_en_n), .FILTERED_SHIFT_CLOCK_I(fa_sck),
    .FILTERED_SERIAL_OUT_O(fa_out), .FILTERED_SERIAL_OE_O(fa_oe),
    .NOLATENCY_READ_ENABLE_N_I(nl_en_n),
    .NOLATENCY_SHIFT_CLOCK_I(nl_sck), .NOLATENCY_SERIAL_OUT_O(nl_out),
    .NOLATENCY_SERIAL_OE_O(nl_oe), .CORE_SAMPLE_I(smp),
    .CORE_START_O(start)
  );
  osadc_serial_host #(.W(32)) u_fa (
    .clk_i(clk), .line_i(fa_line), .en_n_o(fa_en_n), .sck_o(fa_sck)
  );
  osadc_serial_host #(.W(22)) u_nl (
    .clk_i(clk), .line_i(nl_line), .en_n_o(nl_en_n), .sck_o(nl_sck)
  );

  task automatic complete_run;
    if (mismatches == 0 && total_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  task automatic check(input string nm, input logic [31:0] e,
      input logic [31:0] g);
    total_checks++;
    if (g !== e) begin
      mismatches++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic apb(input logic wr, input logic [11:0] a,
      input logic [31:0] d, output logic [31:0] rd, output logic e);
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) @(posedge clk);
    rd = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // composite fields are taken from the core word to expose any latency
  task automatic convert(input logic [31:0] c, output int len);
    int k;
    @(posedge clk);
    smp <= '{core: c, diff: c[21:8], cm: c[7:0]};
    conv <= 1'b1;
    k = 0;
    while (busy !== 1'b1 && k < 8) begin
      @(posedge clk);
      k++;
    end
    len = 0;
    while (busy === 1'b1 && len < 40) begin
      @(posedge clk);
      len++;
    end
    conv <= 1'b0;
    repeat (6) @(posedge clk);
  endtask

  initial begin
    repeat (3) @(posedge clk);
    srst <= 1'b0;
    @(posedge clk);
    check("busy", 32'h0, busy);
    check("drdy_n", 32'h1, drdy_n);
    check("irq", 32'h0, irq);
    foreach (sel_row[i]) begin
      sel0 <= sel_row[i][1];
      decimation_select_1 <= sel_row[i][0];
      repeat (4) @(posedge clk);
      apb(1'b0, 12'h008, 32'h0, q, err);
      check("sel", {30'h0, sel_row[i]}, {30'h0, q[3:2]});
    end
    apb(1'b1, 12'h004, 32'h2, q, err);
    convert(32'h003A_C5A7, n);
    check("busy_len", 32'd16, n);
    check("irq", 32'h1, irq);
    apb(1'b0, 12'h000, 32'h0, q, err);
    check("status", 32'h2, {29'h0, q[2:0]});
    @(posedge clk);
    check("irq", 32'h0, irq);
    apb(1'b0, 12'h020, 32'h0, q, err);
    check("slverr", 32'h1, err);
    check("nl_oe", 32'h0, nl_oe);
    u_nl.read(cw);
    check("comp", 32'h003A_C5A7, {10'h0, cw});
    sel0 <= 1'b0;
    decimation_select_1 <= 1'b0;
    repeat (20) convert(32'h1234_5678, n);
    @(posedge clk);
    sync <= 1'b1;
    repeat (4) @(posedge clk);
    sync <= 1'b0;
    repeat (4) @(posedge clk);
    apb(1'b0, 12'h000, 32'h0, q, err);
    repeat (255) convert(32'hF000_0010, n);
    apb(1'b0, 12'h000, 32'h0, q, err);
    check("early_word", 32'h0, {31'h0, q[0]});
    convert(32'hF000_0010, n);
    check("drdy_n", 32'h0, drdy_n);
    check("fa_oe", 32'h0, fa_oe);
    u_fa.read(w);
    check("filt", 32'hF000_0010, w);
    check("starts", 32'd277, starts);
    complete_run();
  end

  initial begin
    #1500000;
    mismatches++;
    complete_run();
  end
endmodule
`default_nettype wire
